// ==== inc/psc_pkg.sv ====
// shared constants and carriers for the packed string compare unit
package psc_pkg;

    localparam int FRAG_BYTES = 16;
    localparam int BYTE_ELEMS = 16;
    localparam int WORD_ELEMS = 8;
    localparam int MAX_COMPARES = 256;
    localparam int ELEM_W = 17;

    // immediate field positions
    localparam int IMM_FMT_LO = 0;
    localparam int IMM_SIGNED_BIT = 1;
    localparam int IMM_WORD_BIT = 0;
    localparam int IMM_OP_LO = 2;
    localparam int IMM_POL_LO = 4;
    localparam int IMM_OUTSEL_BIT = 6;

    typedef enum logic [1:0] {
        PSC_OP_EQUAL_ANY = 2'h0,
        PSC_OP_RANGES = 2'h1,
        PSC_OP_EQUAL_EACH = 2'h2,
        PSC_OP_EQUAL_ORDERED = 2'h3
    } psc_op_e;

    typedef enum logic [1:0] {
        PSC_POL_PASS = 2'h0,
        PSC_POL_INVERT = 2'h1,
        PSC_POL_PASS_ALT = 2'h2,
        PSC_POL_MASK_NEG = 2'h3
    } psc_pol_e;

    // register map, byte addresses
    localparam logic [7:0] PSC_CTRL_OFS = 8'h00;
    localparam logic [7:0] PSC_CAPS_OFS = 8'h04;
    localparam logic [7:0] PSC_COUNT_OFS = 8'h08;
    localparam logic [7:0] PSC_STATUS_OFS = 8'h0c;

    localparam int PSC_CTRL_ENABLE_BIT = 0;
    localparam logic PSC_CTRL_ENABLE_RST = 1'h1;
    localparam int PSC_CAPS_FEATURE_BIT = 20;
    localparam logic [31:0] PSC_COUNT_RST = 32'h0;

    localparam logic [1:0] PSC_RESP_OKAY = 2'h0;
    localparam logic [1:0] PSC_RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [127:0] fragOne;
        logic [127:0] fragTwo;
        logic [31:0] lenOne;
        logic [31:0] lenTwo;
        logic [7:0] imm;
        logic explicitLen;
        logic maskForm;
    } psc_issue_s;

    typedef struct packed {
        logic [4:0] index;
        logic [127:0] mask;
        logic maskForm;
        logic nonzeroResultFlag;
        logic secondFragmentShortFlag;
        logic firstFragmentShortFlag;
        logic resultBit0Flag;
    } psc_result_s;

endpackage

// ==== verilog/psc_unit.sv ====
// packed string compare execution unit with axi4-lite control registers
//
// Operation
// - compare two 16-byte fragments, byte or word elements, all pairs
// - first match vector is 16 bits for bytes, 8 for words
// - immediate bits 1:0 pick signedness and element size
// - op 00: bit i set if fragment two element i equals any
// - op 01: bit i set if element i within any fragment one range
// - op 10: bit i set if element i equals same-position element
// - op 11: bit i set if substring from i matches fragment one start
// - polarity 00 and 10 pass, 01 inverts every bit
// - polarity 11 inverts only where fragment two element is valid
// - index form, bit 6 clear: lowest set bit, else element count
// - index form, bit 6 set: highest set bit, else element count
// - mask form: zero-extended vector or per-element sign-extended bits
// - index form returns an index, mask form returns a mask
// - implicit variants take length from null termination
// - explicit variants take lengths from the two length operands
// - arithmetic compare only when both elements are valid
// - pairs with invalid elements take the forced per-op values
// - nonzero flag set if result nonzero; bit0 flag takes result bit 0
// - second-fragment short flag set when any fragment two element invalid
// - first-fragment short flag set when any fragment one element invalid
// - fragment operands accepted at any byte alignment
// - capability bit 20 reports support; software checks it first
`timescale 1ns/1ps
module psc_unit #(
    parameter int ADDR_W = 8,
    parameter bit FEATURE_PRESENT = 1'b1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic issueValid,
    input wire psc_pkg::psc_issue_s issue,
    output logic issueReady,
    output logic resultValid,
    output psc_pkg::psc_result_s result,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // the register decode reads address bits 7:2
    if (ADDR_W < 8 || ADDR_W > 32)
    begin : gAddrCheck
        $error("psc_unit: ADDR_W must be 8..32");
    end

    localparam int N = psc_pkg::BYTE_ELEMS;

    // element decode
    logic wordMode;
    logic signedMode;
    logic [4:0] elemCount;
    logic [N-1:0] elemMask;
    logic signed [psc_pkg::ELEM_W-1:0] elemOne [N];
    logic signed [psc_pkg::ELEM_W-1:0] elemTwo [N];
    logic [N-1:0] validOne;
    logic [N-1:0] validTwo;
    logic [31:0] absOne;
    logic [31:0] absTwo;
    logic [4:0] satOne;
    logic [4:0] satTwo;
    logic [N-1:0] firstMatch;
    logic [N-1:0] polarMatch;
    logic [4:0] indexNext;
    logic [127:0] maskNext;
    psc_pkg::psc_op_e compareOp;
    psc_pkg::psc_pol_e polarity;

    // registers
    logic ctrlEnable_reg;
    logic [31:0] count_reg;
    logic issueReady_reg;
    logic resultValid_reg;
    psc_pkg::psc_result_s result_reg;

    assign wordMode = issue.imm[psc_pkg::IMM_FMT_LO + psc_pkg::IMM_WORD_BIT];
    assign signedMode = issue.imm[psc_pkg::IMM_FMT_LO + psc_pkg::IMM_SIGNED_BIT];
    assign compareOp = psc_pkg::psc_op_e'(issue.imm[psc_pkg::IMM_OP_LO +: 2]);
    assign polarity = psc_pkg::psc_pol_e'(issue.imm[psc_pkg::IMM_POL_LO +: 2]);
    assign elemCount = wordMode ? 5'(psc_pkg::WORD_ELEMS) : 5'(psc_pkg::BYTE_ELEMS);
    // negative lengths count by magnitude, as the instruction set does
    assign absOne = issue.lenOne[31] ? 32'(-issue.lenOne) : issue.lenOne;
    assign absTwo = issue.lenTwo[31] ? 32'(-issue.lenTwo) : issue.lenTwo;
    assign satOne = (absOne > 32'(elemCount)) ? elemCount : absOne[4:0];
    assign satTwo = (absTwo > 32'(elemCount)) ? elemCount : absTwo[4:0];

    // operands come in as register values, so no alignment is checked here
    always_comb
    begin
        logic nullOne;
        logic nullTwo;
        nullOne = 1'b0;
        nullTwo = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            elemMask[i] = (5'(i) < elemCount);
            if (wordMode)
            begin
                if (i < psc_pkg::WORD_ELEMS)
                begin
                    elemOne[i] = {signedMode & issue.fragOne[16*i+15], issue.fragOne[16*i +: 16]};
                    elemTwo[i] = {signedMode & issue.fragTwo[16*i+15], issue.fragTwo[16*i +: 16]};
                end
                else
                begin
                    elemOne[i] = '0;
                    elemTwo[i] = '0;
                end
            end
            else
            begin
                elemOne[i] = {{9{signedMode & issue.fragOne[8*i+7]}}, issue.fragOne[8*i +: 8]};
                elemTwo[i] = {{9{signedMode & issue.fragTwo[8*i+7]}}, issue.fragTwo[8*i +: 8]};
            end
            if (issue.explicitLen)
            begin
                validOne[i] = (5'(i) < satOne);
                validTwo[i] = (5'(i) < satTwo);
            end
            else
            begin
                nullOne = nullOne | (elemOne[i] == '0);
                nullTwo = nullTwo | (elemTwo[i] == '0);
                validOne[i] = elemMask[i] & ~nullOne;
                validTwo[i] = elemMask[i] & ~nullTwo;
            end
        end
    end

    // full pair matrix: up to 16x16 compares in one cycle
    always_comb
    begin
        logic hit;
        logic pairOk;
        hit = 1'b0;
        pairOk = 1'b0;
        for (int i = 0; i < N; i++)
        begin
            hit = 1'b0;
            unique case (compareOp)
                psc_pkg::PSC_OP_EQUAL_ANY:
                begin
                    for (int j = 0; j < N; j++)
                    begin
                        // invalid pairs force false
                        hit = hit | (validOne[j] & validTwo[i] & (elemOne[j] == elemTwo[i]));
                    end
                end
                psc_pkg::PSC_OP_RANGES:
                begin
                    for (int j = 0; j < N; j += 2)
                    begin
                        pairOk = validOne[j] & validOne[j+1] & validTwo[i];
                        hit = hit | (pairOk & (elemTwo[i] >= elemOne[j])
                            & (elemTwo[i] <= elemOne[j+1]));
                    end
                end
                psc_pkg::PSC_OP_EQUAL_EACH:
                begin
                    if (validOne[i] & validTwo[i])
                    begin
                        hit = (elemOne[i] == elemTwo[i]);
                    end
                    else
                    begin
                        hit = ~validOne[i] & ~validTwo[i];
                    end
                end
                psc_pkg::PSC_OP_EQUAL_ORDERED:
                begin
                    hit = 1'b1;
                    for (int k = 0; k < N; k++)
                    begin
                        // past the 16 bytes counts as a partial match, also for words
                        if (5'(i + k) < elemCount)
                        begin
                            if (!validOne[k])
                            begin
                                pairOk = 1'b1;
                            end
                            else if (!validTwo[i+k])
                            begin
                                pairOk = 1'b0;
                            end
                            else
                            begin
                                pairOk = (elemOne[k] == elemTwo[i+k]);
                            end
                            hit = hit & pairOk;
                        end
                    end
                end
            endcase
            firstMatch[i] = hit & elemMask[i];
        end
    end

    always_comb
    begin
        unique case (polarity)
            psc_pkg::PSC_POL_INVERT:
            begin
                polarMatch = ~firstMatch & elemMask;
            end
            psc_pkg::PSC_POL_MASK_NEG:
            begin
                polarMatch = (firstMatch ^ validTwo) & elemMask;
            end
            default:
            begin
                polarMatch = firstMatch;
            end
        endcase
    end

    always_comb
    begin
        indexNext = elemCount;
        if (issue.imm[psc_pkg::IMM_OUTSEL_BIT])
        begin
            for (int i = 0; i < N; i++)
            begin
                if (polarMatch[i])
                begin
                    indexNext = 5'(i);
                end
            end
        end
        else
        begin
            for (int i = N - 1; i >= 0; i--)
            begin
                if (polarMatch[i])
                begin
                    indexNext = 5'(i);
                end
            end
        end
    end

    always_comb
    begin
        maskNext = {112'h0, polarMatch};
        if (issue.imm[psc_pkg::IMM_OUTSEL_BIT])
        begin
            for (int i = 0; i < N; i++)
            begin
                if (wordMode)
                begin
                    if (i < psc_pkg::WORD_ELEMS)
                    begin
                        maskNext[16*i +: 16] = {16{polarMatch[i]}};
                    end
                end
                else
                begin
                    maskNext[8*i +: 8] = {8{polarMatch[i]}};
                end
            end
        end
    end

    // issue accepted only while software has the unit enabled
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            issueReady_reg <= 1'b0;
        end
        else
        begin
            issueReady_reg <= ctrlEnable_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            resultValid_reg <= 1'b0;
            result_reg <= '0;
        end
        else
        begin
            resultValid_reg <= issueValid & issueReady_reg;
            if (issueValid & issueReady_reg)
            begin
                result_reg.maskForm <= issue.maskForm;
                result_reg.index <= indexNext;
                result_reg.mask <= maskNext;
                result_reg.nonzeroResultFlag <= |polarMatch;
                result_reg.resultBit0Flag <= polarMatch[0];
                result_reg.secondFragmentShortFlag <= |(~validTwo & elemMask);
                result_reg.firstFragmentShortFlag <= |(~validOne & elemMask);
            end
        end
    end

    assign issueReady = issueReady_reg;
    assign resultValid = resultValid_reg;
    assign result = result_reg;

    // axi4-lite slave
    logic awHeld_reg;
    logic wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic awReady_reg;
    logic wReady_reg;
    logic bValid_reg;
    logic [1:0] bResp_reg;
    logic arReady_reg;
    logic rValid_reg;
    logic [1:0] rResp_reg;
    logic [31:0] rData_reg;
    logic awTake;
    logic wTake;
    logic awHeldNext;
    logic wHeldNext;
    logic doWrite;
    logic countClear;
    logic bValidNext;
    logic arTake;
    logic rValidNext;

    assign awTake = s_axi_awvalid & awReady_reg;
    assign wTake = s_axi_wvalid & wReady_reg;
    assign doWrite = awHeld_reg & wHeld_reg & ~bValid_reg;
    assign awHeldNext = doWrite ? 1'b0 : (awHeld_reg | awTake);
    assign wHeldNext = doWrite ? 1'b0 : (wHeld_reg | wTake);
    assign bValidNext = doWrite | (bValid_reg & ~s_axi_bready);
    assign countClear = doWrite & (awAddr_reg == psc_pkg::PSC_COUNT_OFS);
    assign arTake = s_axi_arvalid & arReady_reg;
    assign rValidNext = arTake | (rValid_reg & ~s_axi_rready);

    // ready is a flop, so each is only offered when its own channel holds nothing and no response is pending
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awReady_reg <= 1'b0;
            wReady_reg <= 1'b0;
            awAddr_reg <= '0;
            wData_reg <= '0;
            wStrb_reg <= '0;
            bValid_reg <= 1'b0;
            bResp_reg <= psc_pkg::PSC_RESP_OKAY;
        end
        else
        begin
            awHeld_reg <= awHeldNext;
            wHeld_reg <= wHeldNext;
            awReady_reg <= ~awHeldNext & ~bValidNext & ~doWrite;
            wReady_reg <= ~wHeldNext & ~bValidNext & ~doWrite;
            bValid_reg <= bValidNext;
            if (awTake)
            begin
                awAddr_reg <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (wTake)
            begin
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                bResp_reg <= (awAddr_reg == psc_pkg::PSC_CTRL_OFS
                    || awAddr_reg == psc_pkg::PSC_COUNT_OFS)
                    ? psc_pkg::PSC_RESP_OKAY : psc_pkg::PSC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctrlEnable_reg <= psc_pkg::PSC_CTRL_ENABLE_RST;
        end
        else if (doWrite && awAddr_reg == psc_pkg::PSC_CTRL_OFS && wStrb_reg[0])
        begin
            ctrlEnable_reg <= wData_reg[psc_pkg::PSC_CTRL_ENABLE_BIT];
        end
    end

    // a completion in the clearing cycle still counts
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            count_reg <= psc_pkg::PSC_COUNT_RST;
        end
        else if (countClear)
        begin
            count_reg <= {31'h0, resultValid_reg};
        end
        else if (resultValid_reg)
        begin
            count_reg <= count_reg + 32'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            arReady_reg <= 1'b0;
            rValid_reg <= 1'b0;
            rResp_reg <= psc_pkg::PSC_RESP_OKAY;
            rData_reg <= '0;
        end
        else
        begin
            arReady_reg <= ~rValidNext;
            rValid_reg <= rValidNext;
            if (arTake)
            begin
                rResp_reg <= psc_pkg::PSC_RESP_OKAY;
                unique case ({s_axi_araddr[7:2], 2'h0})
                    psc_pkg::PSC_CTRL_OFS:
                    begin
                        rData_reg <= {31'h0, ctrlEnable_reg};
                    end
                    psc_pkg::PSC_CAPS_OFS:
                    begin
                        rData_reg <= 32'(FEATURE_PRESENT) << psc_pkg::PSC_CAPS_FEATURE_BIT;
                    end
                    psc_pkg::PSC_COUNT_OFS:
                    begin
                        rData_reg <= count_reg;
                    end
                    psc_pkg::PSC_STATUS_OFS:
                    begin
                        rData_reg <= {27'h0, result_reg.resultBit0Flag,
                            result_reg.firstFragmentShortFlag,
                            result_reg.secondFragmentShortFlag,
                            result_reg.nonzeroResultFlag, 1'b0};
                    end
                    default:
                    begin
                        rData_reg <= 32'h0;
                        rResp_reg <= psc_pkg::PSC_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    assign s_axi_awready = awReady_reg;
    assign s_axi_wready = wReady_reg;
    assign s_axi_bvalid = bValid_reg;
    assign s_axi_bresp = bResp_reg;
    assign s_axi_arready = arReady_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rresp = rResp_reg;
    assign s_axi_rdata = rData_reg;

endmodule // psc_unit

// ==== test/psc_unit_properties.sv ====
// port-level checks of the packed string compare unit
`timescale 1ns/1ps
module psc_unit_properties (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic issueValid,
    input wire psc_pkg::psc_issue_s issue,
    input wire logic issueReady,
    input wire logic resultValid,
    input wire psc_pkg::psc_result_s result
);
    logic take;
    assign take = issueValid && issueReady;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    issue_latency_a: assert property (take |=> resultValid)
        else $error("no result after issue");
    no_spurious_a: assert property (!take |=> !resultValid)
        else $error("result without issue");
    nonzero_flag_a: assert property (resultValid |->
        result.nonzeroResultFlag == (result.mask != '0))
        else $error("nonzero flag wrong");
    bit0_flag_a: assert property (resultValid |->
        result.resultBit0Flag == result.mask[0])
        else $error("bit0 flag wrong");
    // empty result reports the element count of the issued format
    zero_index_a: assert property (take ##1 !result.nonzeroResultFlag |->
        result.index == ($past(issue.imm[0]) ? 5'h08 : 5'h10))
        else $error("empty index wrong");
    word_width_a: assert property (take && issue.imm[0] && !issue.imm[6] |=>
        result.mask[127:8] == '0)
        else $error("word vector too wide");
    zero_ext_a: assert property (take && !issue.imm[6] |=>
        result.mask[127:16] == '0)
        else $error("mask not zero extended");
    second_full_a: assert property (take && issue.explicitLen && !issue.imm[0] &&
        issue.lenTwo == 32'h10 |=> !result.secondFragmentShortFlag)
        else $error("short flag on full fragment");
endmodule // psc_unit_properties

bind psc_unit psc_unit_properties psc_unit_properties_i (.clock, .rst_n, .issueValid,
    .issue, .issueReady, .resultValid, .result);

// ==== test/psc_pipe_model.sv ====
// issuing pipeline stand-in: holds each instruction until the unit takes it
`timescale 1ns/1ps
module psc_pipe_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire psc_pkg::psc_issue_s reqIssue,
    input wire logic issueReady,
    output logic issueValid,
    output psc_pkg::psc_issue_s issue
);
    initial
    begin
        issueValid = 1'h0;
        issue = '0;
    end
    // idle operands churn so a stale value never passes for a request
    always @(posedge clock)
    begin
        if (!rst_n)
            issueValid <= 1'h0;
        else if (!issueValid || issueReady)
        begin
            issueValid <= reqValid;
            issue <= reqValid ? reqIssue : ~issue;
        end
    end
endmodule // psc_pipe_model

// ==== test/psc_unit_bench.sv ====
// self-checking bench for the packed string compare unit
`timescale 1ns/1ps
module psc_unit_bench;
    logic clock;
    logic rst_n;
    logic reqValid;
    logic issueValid;
    logic issueReady;
    logic resultValid;
    psc_pkg::psc_issue_s reqIssue;
    psc_pkg::psc_issue_s issue;
    psc_pkg::psc_result_s result;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int errCount;
    int nCompared;

    psc_pipe_model psc_pipe_model_i (.clock, .rst_n, .reqValid, .reqIssue, .issueReady,
        .issueValid, .issue);
    psc_unit psc_unit_i (.clock, .rst_n, .issueValid, .issue, .issueReady, .resultValid,
        .result, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    task automatic finish_test;
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [127:0] got, input logic [127:0] exp, input string what);
        nCompared++;
        if (got !== exp)
        begin
            errCount++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic bound(input int i);
        if (i >= 40)
        begin
            errCount++;
            $display("[ERR] %0t wait bound used up", $time);
            finish_test();
        end
    endtask

    // 2'h3 marks a response that is not judged
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'h0;
        bound(i);
        if (er !== 2'h3)
            cmp(s_axi_bresp, er, "bresp");
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        int i;
        @(posedge clock);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid)
                break;
        end
        s_axi_rready <= 1'h0;
        bound(i);
        d = s_axi_rdata;
        cmp(s_axi_rresp, er, "rresp");
    endtask

    task automatic send(input psc_pkg::psc_issue_s s);
        @(posedge clock);
        reqIssue <= s;
        reqValid <= 1'h1;
        @(posedge clock);
        reqValid <= 1'h0;
    endtask

    task automatic wait_res(input logic [4:0] eIdx, input logic [127:0] eMask,
            input logic mf, input logic [3:0] eFlg);
        int i;
        for (i = 0; i < 40; i++)
        begin
            @(posedge clock);
            if (resultValid === 1'h1)
                break;
        end
        bound(i);
        cmp(result.index, eIdx, "index");
        cmp(result.mask, eMask, "mask");
        cmp(result.maskForm, mf, "form");
        cmp({result.nonzeroResultFlag, result.secondFragmentShortFlag,
            result.firstFragmentShortFlag, result.resultBit0Flag}, eFlg, "flags");
    endtask

    task automatic op(input logic [127:0] f1, input logic [127:0] f2, input logic [31:0] l1,
            input logic [31:0] l2, input logic [7:0] imm, input logic ex, input logic mf,
            input logic [4:0] eIdx, input logic [127:0] eMask, input logic [3:0] eFlg);
        send(psc_pkg::psc_issue_s'{f1, f2, l1, l2, imm, ex, mf});
        wait_res(eIdx, eMask, mf, eFlg);
    endtask

    task automatic t_regs;
        axi_rd(psc_pkg::PSC_CAPS_OFS, psc_pkg::PSC_RESP_OKAY, rd);
        cmp(rd[20], 1'h1, "feature bit");
        axi_rd(psc_pkg::PSC_CTRL_OFS, psc_pkg::PSC_RESP_OKAY, rd);
        cmp(rd[0], 1'h1, "enable reset");
        axi_rd(8'h40, psc_pkg::PSC_RESP_SLVERR, rd);
        cmp(rd, 32'h0, "unmapped read");
        axi_wr(psc_pkg::PSC_CAPS_OFS, 32'h0, psc_pkg::PSC_RESP_SLVERR);
        $display("test regs done");
    endtask

    // implicit lengths: null bytes end both fragments
    task automatic t_implicit;
        op(128'h6261, 128'h616278, 0, 0, 8'h00, 0, 0, 5'h01, 128'h6, 4'he);
        op(128'h6261, 128'h616278, 0, 0, 8'h40, 0, 1, 5'h02, 128'hffff00, 4'he);
        op(128'h7a61, 128'h623141, 0, 0, 8'h04, 0, 0, 5'h02, 128'h4, 4'he);
        op(128'h636261, 128'h646261, 0, 0, 8'h08, 0, 0, 5'h00, 128'hfffb, 4'hf);
        op(128'h636261, 128'h646261, 0, 0, 8'h18, 0, 0, 5'h02, 128'h4, 4'he);
        op(128'h636261, 128'h646261, 0, 0, 8'h28, 0, 0, 5'h00, 128'hfffb, 4'hf);
        op(128'h636261, 128'h646261, 0, 0, 8'h78, 0, 0, 5'h0f, {{14{8'hff}}, 16'h0}, 4'he);
        op(128'h6261, 128'h62616261, 0, 0, 8'h0c, 0, 0, 5'h00, 128'h5, 4'hf);
        $display("test implicit done");
    endtask

    // explicit lengths: signed words, saturated and negative lengths
    task automatic t_explicit;
        op(128'h10fff0, 128'h1234fff580000005, 2, 3, 8'h07, 1, 0, 0, 128'h5, 4'hf);
        op(128'h10fff0, 128'h1234fff580000005, 2, 3, 8'h05, 1, 0, 8, 128'h0, 4'h6);
        op(128'h10fff0, 128'h1234fff580000005, 2, 3, 8'h47, 1, 1, 2,
            128'hffff0000ffff, 4'hf);
        op({16{8'h41}}, {16{8'h41}}, 16, -20, 8'h08, 1, 0, 0, 128'hffff, 4'h9);
        op({16{8'h41}}, {16{8'h41}}, -20, 16, 8'h58, 1, 0, 16, 128'h0, 4'h0);
        op(128'h1, 128'h1, 0, 0, 8'h01, 1, 0, 8, 128'h0, 4'h6);
        op(128'h620061, {16'h61, 112'h0}, 2, 8, 8'h0d, 1, 0, 7, 128'h80, 4'ha);
        $display("test explicit done");
    endtask

    // a refused issue stays held by the pipeline until enable returns
    task automatic t_refuse;
        int i;
        axi_wr(psc_pkg::PSC_CTRL_OFS, 32'h0, psc_pkg::PSC_RESP_OKAY);
        send(psc_pkg::psc_issue_s'{128'h6261, 128'h616278, 32'h0, 32'h0, 8'h00, 1'h0, 1'h0});
        for (i = 0; i < 8; i++)
        begin
            @(posedge clock);
            cmp(resultValid, 1'h0, "refused issue");
        end
        axi_wr(psc_pkg::PSC_CTRL_OFS, 32'h1, psc_pkg::PSC_RESP_OKAY);
        wait_res(5'h01, 128'h6, 1'h0, 4'he);
        axi_rd(psc_pkg::PSC_COUNT_OFS, psc_pkg::PSC_RESP_OKAY, rd);
        cmp(rd, 32'h10, "result count");
        axi_rd(psc_pkg::PSC_STATUS_OFS, psc_pkg::PSC_RESP_OKAY, rd);
        cmp(rd, 32'he, "status");
        axi_wr(psc_pkg::PSC_COUNT_OFS, 32'h0, psc_pkg::PSC_RESP_OKAY);
        axi_rd(psc_pkg::PSC_COUNT_OFS, psc_pkg::PSC_RESP_OKAY, rd);
        cmp(rd, 32'h0, "count cleared");
        $display("test refuse done");
    endtask

    initial
    begin
        clock = 1'h0;
        forever
            #2 clock = ~clock;
    end

    initial
    begin
        rst_n = 1'h0;
        reqValid = 1'h0;
        reqIssue = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        repeat (16) @(posedge clock);
        rst_n <= 1'h1;
        t_regs();
        t_implicit();
        t_explicit();
        t_refuse();
        finish_test();
    end
endmodule // psc_unit_bench
